// file: common/pmpc_pkg.sv
// shared constants and types for the phy management pin control block
package pmpc_pkg;

    localparam int          PORTS      = 4;
    localparam int          DATA_BITS  = 16;
    localparam int          ADDR_W     = 5;
    localparam int          STRAP_W    = 3;
    localparam int          STRAP_LSB  = 2;
    localparam int          PIN_W      = 7;

    // frame layout: preamble, start, opcode, phy address, reg address
    localparam logic [5:0]  PRE_BITS   = 6'h20;
    localparam logic [3:0]  HDR_LAST   = 4'hb;
    localparam logic [3:0]  DATA_LAST  = 4'hf;
    localparam logic [1:0]  OP_WRITE   = 2'h1;
    localparam logic [1:0]  OP_READ    = 2'h2;

    // synchronised pin vector: {pwr_dn, rst_n, strap[2:0], mdc, mdio}
    localparam int          PIN_GPD    = 6;
    localparam int          PIN_RSTN   = 5;
    localparam int          PIN_STRAP  = 2;
    localparam int          PIN_MDC    = 1;
    localparam int          PIN_MDIO   = 0;
    localparam logic [6:0]  PIN_RST    = 7'h41;

    // tightest sampling margin: minimum management clock period over ref clock
    localparam int          REF_PERIOD_PS = 8000;
    localparam int          MDC_MIN_PS    = 80000;
    localparam int          MDC_MIN_CYC   = MDC_MIN_PS / REF_PERIOD_PS;

    typedef enum logic [2:0] {
        ST_PRE   = 3'h0,
        ST_START = 3'h1,
        ST_HDR   = 3'h2,
        ST_TA    = 3'h3,
        ST_WDATA = 3'h4,
        ST_RDATA = 3'h5
    } pmpc_state_t;

endpackage : pmpc_pkg

// file: core/pmpc_sync.sv
// two-stage synchroniser for pins entering the reference clock domain
`timescale 1ns/1ps
module pmpc_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] din_i,
    output logic      [W-1:0] dout_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= din_i;
            sync_r <= meta_r;
        end
    end

    assign dout_o = sync_r;

endmodule : pmpc_sync

// file: core/pmpc_top.sv
// pin control and management serial slave of a four-port phy
`timescale 1ns/1ps
module pmpc_top #(
    parameter int NPORT = pmpc_pkg::PORTS
) (
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   global_power_down_in_i,
    input  wire logic                   device_reset_n_i,
    input  wire logic                   mgmt_addr_strap_bit2_i,
    input  wire logic                   mgmt_addr_strap_bit3_i,
    input  wire logic                   mgmt_addr_strap_bit4_i,
    input  wire logic                   mdc_i,
    input  wire logic                   mdio_i,
    output logic                        mdio_o,
    output logic                        mdio_oe_o,
    output logic                        mgmt_interrupt_n_o,
    output logic                        mgmt_interrupt_n_oe_o,
    input  wire logic [NPORT-1:0]       port_irq_i,
    output logic      [NPORT-1:0]       port_power_down_o,
    output logic                        led_sync_o,
    output logic                        regs_default_o,
    output logic      [2:0]             phy_base_o,
    output logic                        reg_wr_o,
    output logic                        reg_rd_o,
    output logic      [1:0]             reg_port_o,
    output logic      [4:0]             reg_addr_o,
    output logic      [15:0]            reg_wdata_o,
    input  wire logic [15:0]            reg_rdata_i
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisation

    logic [pmpc_pkg::PIN_W-1:0] pins_raw;
    logic [pmpc_pkg::PIN_W-1:0] pins_s;

    assign pins_raw = {global_power_down_in_i, device_reset_n_i,
                       mgmt_addr_strap_bit4_i, mgmt_addr_strap_bit3_i,
                       mgmt_addr_strap_bit2_i, mdc_i, mdio_i};

    pmpc_sync #(
        .W       (pmpc_pkg::PIN_W),
        .RST_VAL (pmpc_pkg::PIN_RST)
    ) pmpc_sync_inst (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .din_i     (pins_raw),
        .dout_o    (pins_s)
    );

    logic       gpd_s;
    logic       dev_rst;
    logic       mdc_s;
    logic       mdio_s;
    logic [2:0] strap_s;

    assign gpd_s   = pins_s[pmpc_pkg::PIN_GPD];
    assign dev_rst = ~pins_s[pmpc_pkg::PIN_RSTN];
    assign mdc_s   = pins_s[pmpc_pkg::PIN_MDC];
    assign mdio_s  = pins_s[pmpc_pkg::PIN_MDIO];
    assign strap_s = pins_s[pmpc_pkg::PIN_STRAP +: pmpc_pkg::STRAP_W];

    ////////////////////////////////////////////////////////////////////
    // reset pin, strap capture, power-down

    logic       dev_rst_d_r;
    logic       gpd_d_r;
    logic [2:0] phy_base_r;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dev_rst_d_r <= 1'b1;
        end else begin
            dev_rst_d_r <= dev_rst;
        end
    end

    // straps are latched on the cycle the device reset releases
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phy_base_r <= 3'h0;
        end else if (dev_rst_d_r && !dev_rst) begin
            phy_base_r <= strap_s;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            regs_default_o <= 1'b1;
        end else begin
            regs_default_o <= dev_rst;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_power_down_o <= '1;
        end else begin
            port_power_down_o <= {NPORT{gpd_s | dev_rst}};
        end
    end

    // release edge of the shared power-down pin aligns leds across chips
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gpd_d_r    <= 1'b1;
            led_sync_o <= 1'b0;
        end else begin
            gpd_d_r    <= gpd_s;
            led_sync_o <= gpd_d_r & ~gpd_s & ~dev_rst;
        end
    end

    assign phy_base_o = phy_base_r;

    ////////////////////////////////////////////////////////////////////
    // interrupt pin: pulls low only, never drives high

    assign mgmt_interrupt_n_o = 1'b0;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mgmt_interrupt_n_oe_o <= 1'b0;
        end else begin
            mgmt_interrupt_n_oe_o <= (|port_irq_i) & ~dev_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // management clock edge detect

    logic mdc_d_r;
    logic mdc_rise;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mdc_d_r <= 1'b0;
        end else begin
            mdc_d_r <= mdc_s;
        end
    end

    // sampling assumes at least MDC_MIN_CYC ref cycles per mdc period
    assign mdc_rise = mdc_s & ~mdc_d_r;

    ////////////////////////////////////////////////////////////////////
    // frame state machine

    pmpc_pkg::pmpc_state_t state_r;
    logic [5:0]  ones_r;
    logic [3:0]  cnt_r;
    logic [12:0] hdr_r;
    logic [13:0] hdr_full;
    logic [15:0] wsh_r;
    logic [15:0] rsh_r;
    logic        sel_r;
    logic        is_rd_r;
    logic        rd_pend_r;
    logic        hdr_match;
    logic [1:0]  hdr_op;

    assign hdr_full  = {hdr_r, mdio_s};
    // twelve header bits: opcode [11:10], phy address [9:5], reg [4:0]
    assign hdr_op    = hdr_full[11:10];
    assign hdr_match = (hdr_full[9:7] == phy_base_r) &&
                       ((hdr_op == pmpc_pkg::OP_READ) ||
                        (hdr_op == pmpc_pkg::OP_WRITE));

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= pmpc_pkg::ST_PRE;
            ones_r  <= 6'h00;
            cnt_r   <= 4'h0;
            hdr_r   <= 13'h0000;
            sel_r   <= 1'b0;
            is_rd_r <= 1'b0;
        end else if (dev_rst) begin
            state_r <= pmpc_pkg::ST_PRE;
            ones_r  <= 6'h00;
            cnt_r   <= 4'h0;
            sel_r   <= 1'b0;
            is_rd_r <= 1'b0;
        end else if (mdc_rise) begin
            case (state_r)
                pmpc_pkg::ST_PRE: begin
                    if (mdio_s) begin
                        if (ones_r != pmpc_pkg::PRE_BITS) begin
                            ones_r <= ones_r + 6'h01;
                        end
                    end else begin
                        if (ones_r == pmpc_pkg::PRE_BITS) begin
                            state_r <= pmpc_pkg::ST_START;
                        end
                        ones_r <= 6'h00;
                    end
                end
                pmpc_pkg::ST_START: begin
                    cnt_r   <= 4'h0;
                    state_r <= mdio_s ? pmpc_pkg::ST_HDR : pmpc_pkg::ST_PRE;
                end
                pmpc_pkg::ST_HDR: begin
                    hdr_r <= hdr_full[12:0];
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == pmpc_pkg::HDR_LAST) begin
                        sel_r   <= hdr_match;
                        is_rd_r <= (hdr_op == pmpc_pkg::OP_READ);
                        cnt_r   <= 4'h0;
                        state_r <= pmpc_pkg::ST_TA;
                    end
                end
                pmpc_pkg::ST_TA: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r[0]) begin
                        cnt_r   <= 4'h0;
                        state_r <= is_rd_r ? pmpc_pkg::ST_RDATA
                                           : pmpc_pkg::ST_WDATA;
                    end
                end
                pmpc_pkg::ST_WDATA,
                pmpc_pkg::ST_RDATA: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == pmpc_pkg::DATA_LAST) begin
                        cnt_r   <= 4'h0;
                        sel_r   <= 1'b0;
                        state_r <= pmpc_pkg::ST_PRE;
                    end
                end
                default: begin
                    state_r <= pmpc_pkg::ST_PRE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register side requests

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rd_o    <= 1'b0;
            reg_port_o  <= 2'h0;
            reg_addr_o  <= 5'h00;
            rd_pend_r   <= 1'b0;
        end else begin
            reg_rd_o  <= 1'b0;
            rd_pend_r <= reg_rd_o;
            if (!dev_rst && mdc_rise && state_r == pmpc_pkg::ST_HDR &&
                cnt_r == pmpc_pkg::HDR_LAST) begin
                reg_port_o <= hdr_full[6:5];
                reg_addr_o <= hdr_full[4:0];
                reg_rd_o   <= hdr_match &&
                              (hdr_op == pmpc_pkg::OP_READ);
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wsh_r       <= 16'h0000;
            reg_wr_o    <= 1'b0;
            reg_wdata_o <= 16'h0000;
        end else begin
            reg_wr_o <= 1'b0;
            if (!dev_rst && mdc_rise &&
                state_r == pmpc_pkg::ST_WDATA) begin
                wsh_r <= {wsh_r[14:0], mdio_s};
                if (cnt_r == pmpc_pkg::DATA_LAST) begin
                    reg_wdata_o <= {wsh_r[14:0], mdio_s};
                    reg_wr_o    <= sel_r;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data line drive: released for ones, pulled low for zeros

    assign mdio_o = 1'b0;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsh_r     <= 16'h0000;
            mdio_oe_o <= 1'b0;
        end else if (dev_rst) begin
            mdio_oe_o <= 1'b0;
        end else if (rd_pend_r) begin
            rsh_r <= reg_rdata_i;
        end else if (mdc_rise) begin
            mdio_oe_o <= 1'b0;
            if (state_r == pmpc_pkg::ST_TA && sel_r && is_rd_r) begin
                if (!cnt_r[0]) begin
                    mdio_oe_o <= 1'b1;
                end else begin
                    mdio_oe_o <= ~rsh_r[15];
                    rsh_r     <= {rsh_r[14:0], 1'b0};
                end
            end else if (state_r == pmpc_pkg::ST_RDATA && sel_r &&
                         cnt_r != pmpc_pkg::DATA_LAST) begin
                mdio_oe_o <= ~rsh_r[15];
                rsh_r     <= {rsh_r[14:0], 1'b0};
            end
        end
    end

endmodule : pmpc_top

// file: dv/pmpc_host_model.sv
// station manager model driving the management clock and data wire
`timescale 1ns/1ps
module pmpc_host_model (
    output logic     mdc_o,
    output logic     mdio_o,
    input wire logic dev_oe_i
);
    logic oe_r = 1'b0;

    // pull-up: wire high unless a party pulls it low
    assign mdio_o = !(oe_r || dev_oe_i);
    initial mdc_o = 1'b0;

    task automatic bit_x(input logic b, output logic s);
        oe_r = !b;
        #80 mdc_o = 1'b1;
        s = mdio_o;
        #80 mdc_o = 1'b0;
    endtask : bit_x

    task automatic frame(input logic [1:0] op, input logic [4:0] pa, ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [47:0] hdr;
        logic        s;
        hdr = {32'hffff_ffff, 2'h1, op, pa, ra,
               ((op == 2'h2) ? 2'h3 : 2'h2)};
        for (int i = 47; i >= 0; i--) bit_x(hdr[i], s);
        for (int i = 15; i >= 0; i--) begin
            bit_x((op == 2'h2) ? 1'b1 : wd[i], s);
            rd[i] = s;
        end
        oe_r = 1'b0;
        // idle half bit, so the next frame drives the wire on a later step
        #80;
    endtask : frame
endmodule : pmpc_host_model

// file: dv/pmpc_monitor.sv
// assertion checker for the phy management pin control block
`timescale 1ns/1ps
module pmpc_monitor #(
    parameter int NPORT = 4
) (
    input wire logic             ref_clk_i,
    input wire logic             rst_i,
    input wire logic             global_power_down_in_i,
    input wire logic             device_reset_n_i,
    input wire logic             mgmt_addr_strap_bit2_i,
    input wire logic             mgmt_addr_strap_bit3_i,
    input wire logic             mgmt_addr_strap_bit4_i,
    input wire logic             mdc_i,
    input wire logic             mdio_o,
    input wire logic             mdio_oe_o,
    input wire logic             mgmt_interrupt_n_o,
    input wire logic             mgmt_interrupt_n_oe_o,
    input wire logic [NPORT-1:0] port_irq_i,
    input wire logic [NPORT-1:0] port_power_down_o,
    input wire logic             led_sync_o,
    input wire logic             regs_default_o,
    input wire logic [2:0]       phy_base_o,
    input wire logic             reg_wr_o,
    input wire logic             reg_rd_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_pd_hold: assert property (global_power_down_in_i [*5]
        |-> port_power_down_o == '1) else $error("ports not held down");
    a_pd_release: assert property (
        (!global_power_down_in_i && device_reset_n_i) [*7]
        |-> port_power_down_o == '0) else $error("ports not powered up");
    a_led_sync: assert property (
        $fell(global_power_down_in_i) && !regs_default_o
        |-> ##[1:5] led_sync_o) else $error("no led sync pulse");
    a_rst_default: assert property (!device_reset_n_i [*5]
        |-> regs_default_o && port_power_down_o == '1 && !mdio_oe_o)
        else $error("device reset not applied");
    a_strap_base: assert property (!regs_default_o [*3]
        |-> phy_base_o == {mgmt_addr_strap_bit4_i, mgmt_addr_strap_bit3_i,
                           mgmt_addr_strap_bit2_i})
        else $error("address base differs from straps");
    a_irq_follow: assert property (!(|port_irq_i)
        |=> !mgmt_interrupt_n_oe_o) else $error("interrupt without cause");
    a_irq_opendrain: assert property (mgmt_interrupt_n_o == 1'b0)
        else $error("interrupt pin driven high");
    a_mdio_timing: assert property (!mdc_i [*6]
        |-> $stable(mdio_oe_o) && !mdio_o) else $error("data line misdriven");
    a_strobe_pulse: assert property (reg_rd_o || reg_wr_o
        |-> !regs_default_o ##1 !(reg_rd_o || reg_wr_o))
        else $error("bad register strobe");

    cover property (led_sync_o);
    cover property (reg_wr_o);
    cover property (reg_rd_o);
endmodule : pmpc_monitor

// file: dv/pmpc_top_test.sv
// self-checking bench for the phy management pin control block
`timescale 1ns/1ps
module pmpc_top_test;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        gpd = 1'b0;
    logic        dev_rst_n = 1'b0;
    logic [2:0]  strap = 3'h5;
    logic [3:0]  irq = 4'h0;
    logic        mdc, mdio, mdio_o, mdio_oe, int_n, int_oe, led, rdef;
    logic        wr, rd;
    logic [3:0]  pdn;
    logic [2:0]  base;
    logic [1:0]  port;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic [15:0] mem [128];
    int          n_mismatch = 0;
    int          check_count = 0;
    int          n_wr = 0;
    int          n_rd = 0;

    always #4 ref_clk_i = ~ref_clk_i;

    pmpc_top pmpc_top_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .global_power_down_in_i(gpd), .device_reset_n_i(dev_rst_n),
        .mgmt_addr_strap_bit2_i(strap[0]), .mgmt_addr_strap_bit3_i(strap[1]),
        .mgmt_addr_strap_bit4_i(strap[2]), .mdc_i(mdc), .mdio_i(mdio),
        .mdio_o(mdio_o), .mdio_oe_o(mdio_oe), .mgmt_interrupt_n_o(int_n),
        .mgmt_interrupt_n_oe_o(int_oe), .port_irq_i(irq),
        .port_power_down_o(pdn), .led_sync_o(led), .regs_default_o(rdef),
        .phy_base_o(base), .reg_wr_o(wr), .reg_rd_o(rd), .reg_port_o(port),
        .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_rdata_i(mem[{port, addr}]));
    pmpc_host_model host (.mdc_o(mdc), .mdio_o(mdio), .dev_oe_i(mdio_oe));

    always @(posedge ref_clk_i) begin
        if (wr) begin
            mem[{port, addr}] <= wdata;
            n_wr <= n_wr + 1;
        end
        if (rd) n_rd <= n_rd + 1;
    end

    task automatic chk(input string what, input logic [15:0] exp, got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : cyc

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    task automatic t_reset;
        chk("pwr_dn in reset", 16'hf, 16'(pdn));
        dev_rst_n = 1'b1;
        for (int i = 0; i < 20 && rdef !== 1'b0; i++) cyc(1);
        cyc(4);
        chk("phy base", 16'h5, 16'(base));
        chk("pwr_dn released", 16'h0, 16'(pdn));
        $display("t_reset done");
    endtask : t_reset

    task automatic t_power;
        logic [3:0] cnt;
        gpd = 1'b1;
        cyc(6);
        chk("pwr_dn held", 16'hf, 16'(pdn));
        gpd = 1'b0;
        cnt = 4'h0;
        repeat (8) begin
            cyc(1);
            cnt = cnt + 4'(led);
        end
        chk("led sync pulses", 16'h1, 16'(cnt));
        chk("pwr_dn up", 16'h0, 16'(pdn));
        $display("t_power done");
    endtask : t_power

    task automatic t_regs;
        logic [15:0] rv;
        for (int p = 0; p < 4; p++)
            host.frame(2'h1, {3'h5, 2'(p)}, 5'(31 - p * 9),
                       16'hc3a0 + 16'(p), rv);
        chk("write strobes", 16'h4, 16'(n_wr));
        for (int p = 3; p >= 0; p--) begin
            host.frame(2'h2, {3'h5, 2'(p)}, 5'(31 - p * 9), 16'h0, rv);
            chk("read data", 16'hc3a0 + 16'(p), rv);
        end
        chk("read strobes", 16'h4, 16'(n_rd));
        $display("t_regs done");
    endtask : t_regs

    task automatic t_foreign;
        logic [15:0] rv;
        host.frame(2'h1, 5'h13, 5'h2, 16'h1234, rv);
        for (int o = 0; o < 4; o += 3)
            host.frame(2'(o), 5'h14, 5'h0, 16'h0, rv);
        host.frame(2'h2, 5'h13, 5'h2, 16'h0, rv);
        chk("foreign read", 16'hffff, rv);
        chk("refused strobes", 16'h8, 16'(n_wr + n_rd));
        $display("t_foreign done");
    endtask : t_foreign

    task automatic t_irq;
        irq = 4'h4;
        cyc(3);
        chk("irq pulls line", 16'h1, 16'(int_oe));
        chk("irq pin level", 16'h0, 16'(int_n));
        dev_rst_n = 1'b0;
        cyc(6);
        chk("irq in reset", 16'h0, 16'(int_oe));
        chk("defaults in reset", 16'h1, 16'(rdef));
        dev_rst_n = 1'b1;
        cyc(10);
        irq = 4'h0;
        cyc(3);
        chk("irq released", 16'h0, 16'(int_oe));
        $display("t_irq done");
    endtask : t_irq

    initial begin
        #300_000;
        $display("watchdog expired");
        n_mismatch++;
        finish_test;
    end

    initial begin
        cyc(2);
        rst_i = 1'b0;
        cyc(2);
        t_reset;
        t_power;
        t_regs;
        t_foreign;
        t_irq;
        finish_test;
    end
endmodule : pmpc_top_test

bind pmpc_top pmpc_monitor #(.NPORT(NPORT)) pmpc_monitor_inst (
    .ref_clk_i              (ref_clk_i),
    .rst_i                  (rst_i),
    .global_power_down_in_i (global_power_down_in_i),
    .device_reset_n_i       (device_reset_n_i),
    .mgmt_addr_strap_bit2_i (mgmt_addr_strap_bit2_i),
    .mgmt_addr_strap_bit3_i (mgmt_addr_strap_bit3_i),
    .mgmt_addr_strap_bit4_i (mgmt_addr_strap_bit4_i),
    .mdc_i                  (mdc_i),
    .mdio_o                 (mdio_o),
    .mdio_oe_o              (mdio_oe_o),
    .mgmt_interrupt_n_o     (mgmt_interrupt_n_o),
    .mgmt_interrupt_n_oe_o  (mgmt_interrupt_n_oe_o),
    .port_irq_i             (port_irq_i),
    .port_power_down_o      (port_power_down_o),
    .led_sync_o             (led_sync_o),
    .regs_default_o         (regs_default_o),
    .phy_base_o             (phy_base_o),
    .reg_wr_o               (reg_wr_o),
    .reg_rd_o               (reg_rd_o)
);
